// *** pll_holdover_defines.svh ***
// Register offsets, field positions and reset values for PLL reference and holdover control
`ifndef PLL_HOLDOVER_DEFINES_SVH
`define PLL_HOLDOVER_DEFINES_SVH
`define REF_HOLD_CTRL_ADDR 10'h01D
`define ZERO_DELAY_CTRL_ADDR 10'h01E
`define PLL_STATUS_ADDR 10'h01F
`define STATUS_SEL_ADDR 10'h017
`define REF_HOLD_RESET 8'h80
`define ZERO_DELAY_RESET 8'h00
`define STATUS_SEL_RESET 8'h00
`define REF_HOLD_MASK 8'hFB
`define ZERO_DELAY_MASK 8'h1E
`define STATUS_SEL_MASK 8'hFC
`define BIT_STATUS_EEPROM 7
`define BIT_XTAL_AMP 6
`define BIT_DOUBLER 5
`define BIT_STATUS_FREEZE 4
`define BIT_LD_CMP 3
`define BIT_HOLD_EXT 1
`define BIT_HOLD_EN 0
`define BIT_ZD_MODE 2
`define BIT_ZD_EN 1
`define ZD_FB_LSB 3
`define STATUS_SEL_LSB 2
`define PIN_SYNC_RESET 3'h2
`define PLL_STATUS_RESET 8'h00
`endif

// *** pll_holdover_pkg.sv ***
// Types for PLL reference and holdover control
package pll_holdover_pkg;
	typedef struct packed {
		logic status_eeprom_sel;
		logic xtal_amp_en;
		logic doubler_en;
		logic status_freeze;
		logic ld_cmp_en;
		logic hold_external;
		logic hold_en;
	} ref_hold_t;
	typedef struct packed {
		logic [1:0] fb_div_sel;
		logic zd_mode_external;
		logic zd_en;
	} zero_delay_t;
	typedef enum logic [1:0] {
		HOLD_OFF = 2'b01,
		HOLD_ON = 2'b10
	} hold_state_t;
endpackage

// *** pll_holdover_refin_control.sv ***
// PLL reference input, holdover and zero-delay control registers
`timescale 1ns/100ps
`include "pll_holdover_defines.svh"
module pll_holdover_refin_control (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Register port
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Status sources from the PLL core
	input wire logic [5:0] status_sources,
	input wire logic status_eeprom,
	input wire logic [7:0] pll_status_live,
	input wire logic lock_detect_pin,
	input wire logic ref_lost,
	input wire logic sync_pin,
	// Controls to the analog side
	output logic status_pin,
	output logic xtal_amp_en,
	output logic doubler_en,
	output logic ld_cmp_en,
	output logic holdover_active,
	output logic zd_active,
	output logic zd_external,
	output logic [1:0] zd_fb_div
);
	// Register storage
	logic [7:0] ref_hold_q;
	logic [7:0] zero_delay_q;
	logic [7:0] status_sel_q;
	logic [7:0] pll_status_q;
	logic [7:0] pll_status_d;
	logic [7:0] rdata_d;
	// Address decode
	logic sel_ref_hold;
	logic sel_zero_delay;
	logic sel_status_sel;
	logic sel_pll_status;
	// Synchronised pins: bit 0 lock detect, bit 1 sync, bit 2 reference lost
	localparam logic [2:0] pin_idle = `PIN_SYNC_RESET;
	logic [2:0] pin_raw;
	wire [2:0] pin_sync;
	logic ld_sync;
	logic sync_sync;
	logic lost_sync;
	// Holdover decision
	logic locked_seen;
	logic hold_request;
	logic hold_on;
	// Status pin source
	logic [2:0] src_code;
	logic [2:0] src_index;
	logic src_bit;
	pll_holdover_pkg::ref_hold_t rh;
	pll_holdover_pkg::zero_delay_t zd;
	pll_holdover_pkg::hold_state_t hold_q;

	// Named views of the control bits
	assign rh.status_eeprom_sel = ref_hold_q[`BIT_STATUS_EEPROM];
	assign rh.xtal_amp_en = ref_hold_q[`BIT_XTAL_AMP];
	assign rh.doubler_en = ref_hold_q[`BIT_DOUBLER];
	assign rh.status_freeze = ref_hold_q[`BIT_STATUS_FREEZE];
	assign rh.ld_cmp_en = ref_hold_q[`BIT_LD_CMP];
	assign rh.hold_external = ref_hold_q[`BIT_HOLD_EXT];
	assign rh.hold_en = ref_hold_q[`BIT_HOLD_EN];
	assign zd.fb_div_sel = zero_delay_q[`ZD_FB_LSB+1:`ZD_FB_LSB];
	assign zd.zd_mode_external = zero_delay_q[`BIT_ZD_MODE];
	assign zd.zd_en = zero_delay_q[`BIT_ZD_EN];

	assign sel_ref_hold = reg_addr == `REF_HOLD_CTRL_ADDR;
	assign sel_zero_delay = reg_addr == `ZERO_DELAY_CTRL_ADDR;
	assign sel_status_sel = reg_addr == `STATUS_SEL_ADDR;
	assign sel_pll_status = reg_addr == `PLL_STATUS_ADDR;

	// Reference and holdover control; bit 2 never stores
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ref_hold_q <= `REF_HOLD_RESET;
		end else if (reg_wr && sel_ref_hold) begin
			ref_hold_q <= reg_wdata & `REF_HOLD_MASK;
		end
	end

	// Zero-delay control; bits 7:5 and 0 never store
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			zero_delay_q <= `ZERO_DELAY_RESET;
		end else if (reg_wr && sel_zero_delay) begin
			zero_delay_q <= reg_wdata & `ZERO_DELAY_MASK;
		end
	end

	// Status pin selection; only bits 4:2 reach the mux
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			status_sel_q <= `STATUS_SEL_RESET;
		end else if (reg_wr && sel_status_sel) begin
			status_sel_q <= reg_wdata & `STATUS_SEL_MASK;
		end
	end

	// Pins are asynchronous: two flops each before any logic
	assign pin_raw = {ref_lost, sync_pin, lock_detect_pin};
	generate
		for (genvar g = 0; g < 3; g++) begin : g_pin_sync
			logic meta_q;
			logic sync_q;
			// Reset to the idle level so no false request follows reset
			always_ff @(posedge sys_clk) begin
				if (!nrst) begin
					meta_q <= pin_idle[g];
					sync_q <= pin_idle[g];
				end else begin
					meta_q <= pin_raw[g];
					sync_q <= meta_q;
				end
			end
			assign pin_sync[g] = sync_q;
		end
	endgenerate
	assign ld_sync = pin_sync[0];
	assign sync_sync = pin_sync[1];
	assign lost_sync = pin_sync[2];

	// Comparator off: the pin reads as a locked history
	assign locked_seen = rh.ld_cmp_en ? ld_sync : 1'b1;

	// External mode hands holdover to the sync pin (low asserts)
	always_comb begin
		hold_request = 1'b0;
		if (rh.hold_external) begin
			hold_request = !sync_sync;
		end else begin
			hold_request = rh.hold_en && lost_sync && locked_seen;
		end
	end

	// Holdover state; leaves as soon as the request drops
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hold_q <= pll_holdover_pkg::HOLD_OFF;
		end else begin
			case (hold_q)
				pll_holdover_pkg::HOLD_OFF: begin
					if (hold_request) begin
						hold_q <= pll_holdover_pkg::HOLD_ON;
					end
				end
				pll_holdover_pkg::HOLD_ON: begin
					if (!hold_request) begin
						hold_q <= pll_holdover_pkg::HOLD_OFF;
					end
				end
				default: begin
					hold_q <= pll_holdover_pkg::HOLD_OFF;
				end
			endcase
		end
	end
	assign hold_on = hold_q == pll_holdover_pkg::HOLD_ON;

	// Status readback; bit 5 shows the holdover state, bit 7 unused
	assign pll_status_d = {1'b0, pll_status_live[6], hold_on, pll_status_live[4:0]};

	// Frozen copy lets software read a consistent snapshot
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pll_status_q <= `PLL_STATUS_RESET;
		end else if (!rh.status_freeze) begin
			pll_status_q <= pll_status_d;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sel_ref_hold) begin
			rdata_d = ref_hold_q;
		end else if (sel_zero_delay) begin
			rdata_d = zero_delay_q;
		end else if (sel_status_sel) begin
			rdata_d = status_sel_q;
		end else if (sel_pll_status) begin
			rdata_d = pll_status_q;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Codes 6 and 7 wrap onto the first two sources
	assign src_code = status_sel_q[`STATUS_SEL_LSB+2:`STATUS_SEL_LSB];
	always_comb begin
		case (src_code)
			3'h6: src_index = 3'h0;
			3'h7: src_index = 3'h1;
			default: src_index = src_code;
		endcase
	end
	assign src_bit = status_sources[src_index];

	// Status pin; eeprom status overrides the selection
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			status_pin <= 1'b0;
		end else begin
			status_pin <= rh.status_eeprom_sel ? status_eeprom : src_bit;
		end
	end

	// Analog enables follow their control bits one cycle later
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			xtal_amp_en <= 1'b0;
			doubler_en <= 1'b0;
			ld_cmp_en <= 1'b0;
		end else begin
			xtal_amp_en <= rh.xtal_amp_en;
			doubler_en <= rh.doubler_en;
			ld_cmp_en <= rh.ld_cmp_en;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			holdover_active <= 1'b0;
		end else begin
			holdover_active <= hold_on;
		end
	end

	// External mode only counts while zero delay is enabled
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			zd_active <= 1'b0;
			zd_external <= 1'b0;
			zd_fb_div <= 2'h0;
		end else begin
			zd_active <= zd.zd_en;
			zd_external <= zd.zd_en && zd.zd_mode_external;
			zd_fb_div <= zd.fb_div_sel;
		end
	end

	// Checks beside the logic they guard
	a_status_override: assert property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[7] && $stable(ref_hold_q) |=> status_pin == $past(status_eeprom))
		else $error("status pin not following eeprom status");
	a_status_select: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ref_hold_q[7] |=> status_pin == $past(src_bit))
		else $error("status pin not following selected source");

	a_xtal_amp_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 xtal_amp_en == $past(ref_hold_q[6]))
		else $error("crystal amplifier enable mismatch");
	a_doubler_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 doubler_en == $past(ref_hold_q[5]))
		else $error("doubler enable mismatch");
	a_ld_cmp_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 ld_cmp_en == $past(ref_hold_q[3]))
		else $error("comparator enable mismatch");

	a_status_frozen: assert property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[4] |=> $stable(pll_status_q))
		else $error("status readback changed while frozen");
	a_status_refresh: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ref_hold_q[4] |=> pll_status_q == $past(pll_status_d))
		else $error("status readback not refreshed");

	a_ld_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ref_hold_q[3] |-> locked_seen)
		else $error("lock-detect pin not treated as high");
	a_ld_used: assert property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[3] |-> locked_seen == ld_sync)
		else $error("lock-detect comparator not used");

	a_hold_external: assert property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[1] && !sync_sync |=> hold_q == pll_holdover_pkg::HOLD_ON)
		else $error("external holdover not entered");
	a_hold_disabled: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ref_hold_q[1] && !ref_hold_q[0] |=> hold_q == pll_holdover_pkg::HOLD_OFF)
		else $error("holdover entered while disabled");
	a_hold_auto_enter: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ref_hold_q[1] && ref_hold_q[0] && lost_sync && locked_seen |=> hold_on)
		else $error("automatic holdover not entered");
	a_hold_state_valid: assert property (@(posedge sys_clk) disable iff (!nrst)
		$onehot(hold_q))
		else $error("holdover state not one-hot");
	a_holdover_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 holdover_active == $past(hold_on))
		else $error("holdover output mismatch");

	a_zd_divider: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 zd_fb_div == $past(zero_delay_q[4:3]))
		else $error("feedback divider select mismatch");
	a_zd_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
		zd_external |-> zd_active)
		else $error("external zero delay without enable");
	a_zd_off: assert property (@(posedge sys_clk) disable iff (!nrst)
		!zero_delay_q[1] |=> !zd_active && !zd_external)
		else $error("zero delay active while disabled");

	a_unused_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[2] == 1'b0 && zero_delay_q[7:5] == 3'h0 && zero_delay_q[0] == 1'b0)
		else $error("unused bit stored");
	a_status_sel_unused: assert property (@(posedge sys_clk) disable iff (!nrst)
		status_sel_q[1:0] == 2'h0)
		else $error("unused selection bit stored");
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	c_hold_entered: cover property (@(posedge sys_clk) disable iff (!nrst)
		hold_q == pll_holdover_pkg::HOLD_OFF ##1 hold_q == pll_holdover_pkg::HOLD_ON);
	c_zd_external: cover property (@(posedge sys_clk) disable iff (!nrst) zd_external);
	c_status_sel: cover property (@(posedge sys_clk) disable iff (!nrst)
		!ref_hold_q[7] && status_pin);
	c_hold_ld_gated: cover property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[3] && ref_hold_q[0] && lost_sync && !ld_sync);
	c_status_frozen: cover property (@(posedge sys_clk) disable iff (!nrst)
		ref_hold_q[4] && pll_status_q != pll_status_d);
endmodule // pll_holdover_refin_control

// *** testbench.sv ***
// Self-checking testbench for PLL reference, holdover and zero-delay control
`timescale 1ns/100ps
`include "pll_holdover_defines.svh"
module testbench;
	logic sys_clk, nrst, reg_wr, reg_rd, status_eeprom, lock_detect_pin, ref_lost, sync_pin;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pll_status_live, rd;
	logic [5:0] status_sources;
	logic status_pin, xtal_amp_en, doubler_en, ld_cmp_en, holdover_active, zd_active, zd_external;
	logic [1:0] zd_fb_div;
	int miscompares = 0;
	int cmp_count = 0;
	pll_holdover_refin_control pll_holdover_refin_control_inst (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .status_sources(status_sources), .status_eeprom(status_eeprom),
		.pll_status_live(pll_status_live), .lock_detect_pin(lock_detect_pin),
		.ref_lost(ref_lost), .sync_pin(sync_pin), .status_pin(status_pin),
		.xtal_amp_en(xtal_amp_en), .doubler_en(doubler_en), .ld_cmp_en(ld_cmp_en),
		.holdover_active(holdover_active), .zd_active(zd_active), .zd_external(zd_external),
		.zd_fb_div(zd_fb_div));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [9:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	// Pin path needs up to four edges
	task automatic settle;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_reset;
		rdr(`REF_HOLD_CTRL_ADDR);
		chk("ref_hold reset", rd, 8'h80);
		rdr(`ZERO_DELAY_CTRL_ADDR);
		chk("zero_delay reset", rd, 8'h00);
		chk("xtal_amp_en", {7'h00, xtal_amp_en}, 8'h00);
		chk("doubler_en", {7'h00, doubler_en}, 8'h00);
		chk("ld_cmp_en", {7'h00, ld_cmp_en}, 8'h00);
		chk("zd_active", {7'h00, zd_active}, 8'h00);
		chk("zd_external", {7'h00, zd_external}, 8'h00);
		chk("zd_fb_div", {6'h00, zd_fb_div}, 8'h00);
		chk("status_pin eeprom", {7'h00, status_pin}, 8'h01);
	endtask
	task automatic t_ctrl;
		wr(`REF_HOLD_CTRL_ADDR, 8'hFC);
		rdr(`REF_HOLD_CTRL_ADDR);
		chk("ref_hold masked", rd, 8'hF8);
		settle();
		chk("xtal_amp_en on", {7'h00, xtal_amp_en}, 8'h01);
		chk("doubler_en on", {7'h00, doubler_en}, 8'h01);
		chk("ld_cmp_en on", {7'h00, ld_cmp_en}, 8'h01);
		wr(`REF_HOLD_CTRL_ADDR, 8'h00);
		settle();
		chk("controls off", {5'h00, xtal_amp_en, doubler_en, ld_cmp_en}, 8'h00);
	endtask
	task automatic t_status_sel;
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			status_sources <= 6'h01 << (i % 6);
			wr(`STATUS_SEL_ADDR, 8'(i << 2));
			settle();
			chk("status_pin sel one", {7'h00, status_pin}, 8'h01);
			@(posedge sys_clk);
			status_sources <= ~(6'h01 << (i % 6));
			settle();
			chk("status_pin sel zero", {7'h00, status_pin}, 8'h00);
		end
		@(posedge sys_clk);
		status_eeprom <= 1'b0;
		status_sources <= 6'h3F;
		wr(`REF_HOLD_CTRL_ADDR, 8'h80);
		settle();
		chk("status_pin override", {7'h00, status_pin}, 8'h00);
	endtask
	task automatic t_zd;
		for (int k = 0; k < 16; k++) begin
			wr(`ZERO_DELAY_CTRL_ADDR, {3'h7, 4'(k), 1'b1});
			rdr(`ZERO_DELAY_CTRL_ADDR);
			chk("zero_delay masked", rd, {3'h0, 4'(k), 1'b0});
			settle();
			chk("zd_fb_div", {6'h00, zd_fb_div}, 8'(k >> 2));
			chk("zd_active", {7'h00, zd_active}, 8'(k & 1));
			chk("zd_external", {7'h00, zd_external}, 8'((k & 1) & (k >> 1)));
		end
	endtask
	task automatic t_freeze;
		@(posedge sys_clk);
		pll_status_live <= 8'h00;
		wr(`REF_HOLD_CTRL_ADDR, 8'h10);
		settle();
		@(posedge sys_clk);
		pll_status_live <= 8'hFF;
		wr(`PLL_STATUS_ADDR, 8'hFF);
		settle();
		rdr(`PLL_STATUS_ADDR);
		chk("status frozen", rd, 8'h00);
		wr(`REF_HOLD_CTRL_ADDR, 8'h00);
		settle();
		rdr(`PLL_STATUS_ADDR);
		chk("status refreshed", rd, 8'h5F);
	endtask
	task automatic t_hold;
		@(posedge sys_clk);
		ref_lost <= 1'b1;
		lock_detect_pin <= 1'b0;
		settle();
		chk("holdover disabled", {7'h00, holdover_active}, 8'h00);
		wr(`REF_HOLD_CTRL_ADDR, 8'h01);
		settle();
		chk("holdover auto", {7'h00, holdover_active}, 8'h01);
		rdr(`PLL_STATUS_ADDR);
		chk("status holdover bit", rd & 8'h20, 8'h20);
		wr(`REF_HOLD_CTRL_ADDR, 8'h09);
		settle();
		chk("holdover ld low", {7'h00, holdover_active}, 8'h00);
		@(posedge sys_clk);
		lock_detect_pin <= 1'b1;
		settle();
		chk("holdover ld high", {7'h00, holdover_active}, 8'h01);
		@(posedge sys_clk);
		sync_pin <= 1'b1;
		wr(`REF_HOLD_CTRL_ADDR, 8'h02);
		settle();
		chk("holdover ext off", {7'h00, holdover_active}, 8'h00);
		@(posedge sys_clk);
		sync_pin <= 1'b0;
		settle();
		chk("holdover ext on", {7'h00, holdover_active}, 8'h01);
	endtask
	task automatic t_unmapped;
		wr(10'h3FF, 8'hFF);
		rdr(10'h3FF);
		chk("unmapped read", rd, 8'h00);
		rdr(`REF_HOLD_CTRL_ADDR);
		chk("ref_hold after unmapped write", rd, 8'h02);
		@(posedge sys_clk);
		#1 chk("rdata after read", reg_rdata, 8'h00);
	endtask
	initial begin
		nrst = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		status_sources = 6'h00;
		status_eeprom = 1'b1;
		pll_status_live = 8'h00;
		lock_detect_pin = 1'b1;
		ref_lost = 1'b0;
		sync_pin = 1'b1;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		settle();
		t_reset();
		t_ctrl();
		t_status_sel();
		t_zd();
		t_freeze();
		t_hold();
		t_unmapped();
		end_of_test();
	end
	// Tests need roughly 430 cycles; generous margin
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		end_of_test();
	end
endmodule // testbench
